//--- fdsr_host.sv
// Host processor model issuing single-cycle register strobes.
// Assumes the block answers reads within the strobe cycle.
`timescale 1ns/1ps
module fdsr_host
(
    // Clock
    input wire logic clk,
    // Host I/O bus
    output logic [2:0] io_addr,
    output logic io_rd,
    output logic io_wr,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_rdata_oe
);
    initial
    begin
        io_addr = 3'h0;
        io_rd = 1'b0;
        io_wr = 1'b0;
        io_wdata = 8'h00;
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
        io_wdata <= ~d;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d,
        output logic oe);
        @(posedge clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clk);
        d = io_rdata;
        oe = io_rdata_oe;
        io_rd <= 1'b0;
    endtask
endmodule

//--- fdsr_pkg.sv
// Package for the floppy status register bank: offsets, bit positions,
// compatibility modes.
// Assumes an 8-bit host I/O bus with a 3-bit offset inside the block.
package fdsr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [2:0] OFF_STATUS_A = 3'h0;
    localparam logic [2:0] OFF_STATUS_B = 3'h1;
    localparam logic [2:0] OFF_DIGITAL_OUTPUT = 3'h2;
    localparam logic [2:0] OFF_TAPE_DRIVE = 3'h3;
    localparam logic [2:0] OFF_MAIN_STATUS = 3'h4;
    localparam logic [2:0] OFF_DATA_FIFO = 3'h5;
    localparam logic [2:0] OFF_RESERVED = 3'h6;
    localparam logic [2:0] OFF_DIGITAL_INPUT = 3'h7;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int DRATE_POWERDOWN_BIT = 6;
    localparam int AUTO_PWR_FDC_BIT = 0;
    localparam int DOUT_DRIVE_PICK_BIT = 0;
    localparam int DOUT_RESET_N_BIT = 2;
    localparam int DOUT_MOTOR0_BIT = 4;
    localparam int DOUT_MOTOR1_BIT = 5;
    localparam int TAPE_SEL_WIDTH = 2;
    localparam logic [7:0] DOUT_RESET = 8'h00;
    localparam logic [7:0] DRATE_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [1:0] TAPE_RESET = 2'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [1:0] RSVD_ONES = 2'h3;
    // Status A bit positions; bit 6 is drive two in enhanced one, DMA in enhanced two
    localparam int STA_DIRECTION_BIT = 0;
    localparam int STA_PROTECT_BIT = 1;
    localparam int STA_INDEX_BIT = 2;
    localparam int STA_SIDE_BIT = 3;
    localparam int STA_TRACK0_BIT = 4;
    localparam int STA_STEP_BIT = 5;
    localparam int STA_DRIVE2_BIT = 6;
    localparam int STA_DMA_BIT = 6;
    localparam int STA_IRQ_BIT = 7;
    // Status B bit positions
    localparam int STB_MOTOR0_BIT = 0;
    localparam int STB_MOTOR1_BIT = 1;
    localparam int STB_WRITE_GATE_BIT = 2;
    localparam int STB_RD_TOGGLE_BIT = 3;
    localparam int STB_WR_TOGGLE_BIT = 4;
    localparam int STB_PICK_BIT = 5;
    localparam int STB_RSVD_LSB = 6;
    localparam int STB_RSVD_MSB = 7;

    // ------------------------------------------------------------
    // Compatibility modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FDSR_MODE_AT = 2'b00,
        FDSR_MODE_ENH1 = 2'b01,
        FDSR_MODE_ENH2 = 2'b10
    } fdsr_mode_t;

endpackage

//--- fdsr_regs.sv
// Host register decode, drive status registers and drive power-off pin
// of a floppy controller.
// Assumes host strobes are synchronous one-cycle pulses and the mode
// input is held stable while running.
//
// Operation
// - power-off high: shutdown, else auto-down, else powerdown bit
// - power-off output is active high
// - decode eight offsets, others unsupported
// - offset 4 reads main status, writes rate
// - offset 7 reads input register, writes config
// - AT mode: status reads leave bus undriven
// - enhanced modes: status readable any time
// - enhanced one: A0 direction, one inward
// - enhanced one: A1,A2,A4,A6 active low
// - enhanced one: A3 head side, A5 step
// - enhanced modes: A7 mirrors interrupt line
// - enhanced two: A0 direction inverted
// - enhanced two: protect, index, track high; side low
// - enhanced two: A5 latched step, cleared on input read
// - enhanced one: B0,B1 motor outputs, hard reset
// - enhanced one: B2 write gate
// - enhanced one: B3,B4 toggle on data edges
// - enhanced one: B5 mirrors drive pick bit
// - enhanced one: B6,B7 read one
`timescale 1ns/1ps
module fdsr_regs
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Host I/O bus
    input wire logic [2:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rdata_oe,
    // Mode and power configuration
    input wire logic [1:0] compat_mode,
    input wire logic fdc_shutdown,
    input wire logic auto_power_config,
    input wire logic auto_powered_down,
    // Controller core
    input wire logic [7:0] main_status,
    input wire logic [7:0] fifo_rdata,
    input wire logic [7:0] digital_input,
    input wire logic core_irq,
    input wire logic core_drq,
    input wire logic soft_reset,
    output logic fifo_rd,
    output logic fifo_wr,
    output logic [7:0] digital_output,
    output logic [7:0] data_rate_select,
    output logic [7:0] config_control,
    // Drive interface
    input wire logic head_inward_n,
    input wire logic write_protect_n,
    input wire logic index_pulse_n,
    input wire logic track_zero_n,
    input wire logic head_side,
    input wire logic step_out,
    input wire logic second_drive_present_n,
    input wire logic write_gate,
    input wire logic read_data_n,
    input wire logic write_data_n,
    // Drive power
    output logic floppy_power_off
);

    logic [1:0] tape_drive_select;
    logic step_prev_reg;
    logic step_latch_reg;
    logic read_toggle;
    logic write_toggle;
    logic [7:0] drive_status_a;
    logic [7:0] drive_status_b;
    logic status_access;
    logic motor_on_0;
    logic motor_on_1;
    logic drive_pick_bit0;
    logic fdc_reset_n;
    logic rd_input;
    fdsr_pkg::fdsr_mode_t mode;
    logic [7:0] status_a_enh1;
    logic [7:0] status_a_enh2;
    logic [7:0] status_b_enh1;
    logic step_rise;
    logic wr_dout;
    logic wr_tape;
    logic wr_drate;
    logic wr_cfg;

    assign mode = fdsr_pkg::fdsr_mode_t'(compat_mode);
    assign rd_input = io_rd && (io_addr == fdsr_pkg::OFF_DIGITAL_INPUT);
    assign fdc_reset_n = digital_output[fdsr_pkg::DOUT_RESET_N_BIT];
    assign motor_on_0 = digital_output[fdsr_pkg::DOUT_MOTOR0_BIT];
    assign motor_on_1 = digital_output[fdsr_pkg::DOUT_MOTOR1_BIT];
    assign drive_pick_bit0 = digital_output[fdsr_pkg::DOUT_DRIVE_PICK_BIT];
    assign step_rise = step_out && !step_prev_reg;

    // ------------------------------------------------------------
    // Write strobes
    // ------------------------------------------------------------
    // Offsets 4 and 7 are shared: writes land in rate and config.
    assign wr_dout = io_wr && (io_addr == fdsr_pkg::OFF_DIGITAL_OUTPUT);
    assign wr_tape = io_wr && (io_addr == fdsr_pkg::OFF_TAPE_DRIVE);
    assign wr_drate = io_wr && (io_addr == fdsr_pkg::OFF_MAIN_STATUS);
    assign wr_cfg = io_wr && (io_addr == fdsr_pkg::OFF_DIGITAL_INPUT);

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    // Digital output is untouched by software reset; hard reset only.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            digital_output <= fdsr_pkg::DOUT_RESET;
        end
        else if (wr_dout)
        begin
            digital_output <= io_wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tape_drive_select <= fdsr_pkg::TAPE_RESET;
        end
        else if (wr_tape)
        begin
            tape_drive_select <= io_wdata[fdsr_pkg::TAPE_SEL_WIDTH-1:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            data_rate_select <= fdsr_pkg::DRATE_RESET;
        end
        else if (wr_drate)
        begin
            data_rate_select <= io_wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            config_control <= fdsr_pkg::CFG_RESET;
        end
        else if (wr_cfg)
        begin
            config_control <= io_wdata;
        end
    end

    assign fifo_wr = io_wr && (io_addr == fdsr_pkg::OFF_DATA_FIFO);
    assign fifo_rd = io_rd && (io_addr == fdsr_pkg::OFF_DATA_FIFO);

    // ------------------------------------------------------------
    // Latched step
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            step_prev_reg <= 1'b0;
        end
        else
        begin
            step_prev_reg <= step_out;
        end
    end

    // Digital output bit 2 low holds the controller in soft reset.
    // Set wins over the clear from an input-register read or soft reset.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            step_latch_reg <= 1'b0;
        end
        else if (step_rise)
        begin
            step_latch_reg <= 1'b1;
        end
        else if (rd_input || soft_reset || !fdc_reset_n)
        begin
            step_latch_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Data line toggles
    // ------------------------------------------------------------
    // Inactive edge of an active-low data line is its rising edge.
    fdsr_toggle u_read_toggle
    (
        .clk(clk),
        .reset_n(reset_n),
        .level_in(~read_data_n),
        .toggle_out(read_toggle)
    );

    fdsr_toggle u_write_toggle
    (
        .clk(clk),
        .reset_n(reset_n),
        .level_in(~write_data_n),
        .toggle_out(write_toggle)
    );

    // ------------------------------------------------------------
    // Status register layouts
    // ------------------------------------------------------------
    // Enhanced one, status A: live levels, drive polarity kept except A0
    always_comb
    begin
        status_a_enh1 = fdsr_pkg::BYTE_ZERO;
        status_a_enh1[fdsr_pkg::STA_DIRECTION_BIT] = ~head_inward_n;
        status_a_enh1[fdsr_pkg::STA_PROTECT_BIT] = write_protect_n;
        status_a_enh1[fdsr_pkg::STA_INDEX_BIT] = index_pulse_n;
        status_a_enh1[fdsr_pkg::STA_SIDE_BIT] = head_side;
        status_a_enh1[fdsr_pkg::STA_TRACK0_BIT] = track_zero_n;
        status_a_enh1[fdsr_pkg::STA_STEP_BIT] = step_out;
        status_a_enh1[fdsr_pkg::STA_DRIVE2_BIT] = second_drive_present_n;
        status_a_enh1[fdsr_pkg::STA_IRQ_BIT] = core_irq;
    end

    // Enhanced two, status A: inverted polarity except A0, latched step
    always_comb
    begin
        status_a_enh2 = fdsr_pkg::BYTE_ZERO;
        status_a_enh2[fdsr_pkg::STA_DIRECTION_BIT] = head_inward_n;
        status_a_enh2[fdsr_pkg::STA_PROTECT_BIT] = ~write_protect_n;
        status_a_enh2[fdsr_pkg::STA_INDEX_BIT] = ~index_pulse_n;
        status_a_enh2[fdsr_pkg::STA_SIDE_BIT] = ~head_side;
        status_a_enh2[fdsr_pkg::STA_TRACK0_BIT] = ~track_zero_n;
        status_a_enh2[fdsr_pkg::STA_STEP_BIT] = step_latch_reg;
        status_a_enh2[fdsr_pkg::STA_DMA_BIT] = core_drq;
        status_a_enh2[fdsr_pkg::STA_IRQ_BIT] = core_irq;
    end

    // Enhanced one, status B: motors, gate, toggles, pick bit
    always_comb
    begin
        status_b_enh1 = fdsr_pkg::BYTE_ZERO;
        status_b_enh1[fdsr_pkg::STB_MOTOR0_BIT] = motor_on_0;
        status_b_enh1[fdsr_pkg::STB_MOTOR1_BIT] = motor_on_1;
        status_b_enh1[fdsr_pkg::STB_WRITE_GATE_BIT] = write_gate;
        status_b_enh1[fdsr_pkg::STB_RD_TOGGLE_BIT] = read_toggle;
        status_b_enh1[fdsr_pkg::STB_WR_TOGGLE_BIT] = write_toggle;
        status_b_enh1[fdsr_pkg::STB_PICK_BIT] = drive_pick_bit0;
        status_b_enh1[fdsr_pkg::STB_RSVD_MSB:fdsr_pkg::STB_RSVD_LSB] =
            fdsr_pkg::RSVD_ONES;
    end

    // Mode picks the layout; AT mode and the unused code read zero
    always_comb
    begin
        drive_status_a = fdsr_pkg::BYTE_ZERO;
        drive_status_b = fdsr_pkg::BYTE_ZERO;
        unique case (mode)
            fdsr_pkg::FDSR_MODE_ENH1:
            begin
                drive_status_a = status_a_enh1;
                drive_status_b = status_b_enh1;
            end
            fdsr_pkg::FDSR_MODE_ENH2:
            begin
                drive_status_a = status_a_enh2;
            end
            default:
            begin
                drive_status_a = fdsr_pkg::BYTE_ZERO;
                drive_status_b = fdsr_pkg::BYTE_ZERO;
            end
        endcase
    end

    assign status_access = (io_addr == fdsr_pkg::OFF_STATUS_A) ||
        (io_addr == fdsr_pkg::OFF_STATUS_B);

    // ------------------------------------------------------------
    // Read mux, combinational within the read cycle
    // ------------------------------------------------------------
    always_comb
    begin
        io_rdata = fdsr_pkg::BYTE_ZERO;
        io_rdata_oe = 1'b0;
        if (io_rd)
        begin
            io_rdata_oe = 1'b1;
            unique case (io_addr)
                fdsr_pkg::OFF_STATUS_A: io_rdata = drive_status_a;
                fdsr_pkg::OFF_STATUS_B: io_rdata = drive_status_b;
                fdsr_pkg::OFF_DIGITAL_OUTPUT: io_rdata = digital_output;
                fdsr_pkg::OFF_TAPE_DRIVE:
                    io_rdata[fdsr_pkg::TAPE_SEL_WIDTH-1:0] = tape_drive_select;
                fdsr_pkg::OFF_MAIN_STATUS: io_rdata = main_status;
                fdsr_pkg::OFF_DATA_FIFO: io_rdata = fifo_rdata;
                fdsr_pkg::OFF_RESERVED: io_rdata_oe = 1'b0;
                fdsr_pkg::OFF_DIGITAL_INPUT: io_rdata = digital_input;
            endcase
            // AT mode leaves the bus floating on status reads; enhanced
            // modes drive it at any time.
            if (status_access && mode == fdsr_pkg::FDSR_MODE_AT)
            begin
                io_rdata_oe = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Drive power-off pin
    // ------------------------------------------------------------
    // Registered so the pin never glitches while its inputs settle.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            floppy_power_off <= 1'b0;
        end
        else if (fdc_shutdown)
        begin
            floppy_power_off <= 1'b1;
        end
        else if (auto_power_config)
        begin
            floppy_power_off <= auto_powered_down;
        end
        else
        begin
            floppy_power_off <=
                data_rate_select[fdsr_pkg::DRATE_POWERDOWN_BIT];
        end
    end

endmodule

//--- fdsr_regs_chk.sv
// Assertions on the ports of the floppy status register bank.
// Assumes it is bound onto fdsr_regs with one clock and reset domain.
`timescale 1ns/1ps
module fdsr_regs_chk
(
    // Clock, reset and host bus
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [2:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_rdata_oe,
    input wire logic fifo_rd,
    input wire logic fifo_wr,
    // Configuration, core and drive levels
    input wire logic [1:0] compat_mode,
    input wire logic fdc_shutdown,
    input wire logic auto_power_config,
    input wire logic auto_powered_down,
    input wire logic [7:0] main_status,
    input wire logic [7:0] digital_input,
    input wire logic core_irq,
    input wire logic core_drq,
    input wire logic [7:0] digital_output,
    input wire logic [7:0] data_rate_select,
    input wire logic head_inward_n,
    input wire logic write_protect_n,
    input wire logic index_pulse_n,
    input wire logic track_zero_n,
    input wire logic head_side,
    input wire logic step_out,
    input wire logic second_drive_present_n,
    input wire logic write_gate,
    input wire logic floppy_power_off
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire rd0 = io_rd && io_addr == 3'h0;
    property p_fpd;
        $past(reset_n) |-> floppy_power_off == $past(fdc_shutdown ||
            (auto_power_config ? auto_powered_down : data_rate_select[6]));
    endproperty
    a_fpd: assert property (p_fpd) else $error("power-off pin wrong");
    property p_at;
        io_rd && compat_mode == 2'h0 && io_addr < 3'h2 |-> !io_rdata_oe;
    endproperty
    a_at: assert property (p_at) else $error("status driven in AT");
    property p_rsv;
        io_rd && io_addr == 3'h6 |-> !io_rdata_oe;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved driven");
    property p_fifo;
        fifo_rd == (io_rd && io_addr == 3'h5) &&
            fifo_wr == (io_wr && io_addr == 3'h5);
    endproperty
    a_fifo: assert property (p_fifo) else $error("fifo strobe wrong");
    property p_msr;
        io_rd && io_addr == 3'h4 |-> io_rdata_oe && io_rdata == main_status;
    endproperty
    a_msr: assert property (p_msr) else $error("main status wrong");
    property p_dsr;
        io_wr && io_addr == 3'h4 |=> data_rate_select == $past(io_wdata);
    endproperty
    a_dsr: assert property (p_dsr) else $error("rate write lost");
    property p_dir;
        io_rd && io_addr == 3'h7 |-> io_rdata == digital_input;
    endproperty
    a_dir: assert property (p_dir) else $error("input reg wrong");
    property p_a1;
        rd0 && compat_mode == 2'h1 |-> io_rdata_oe && io_rdata == {core_irq,
            second_drive_present_n, step_out, track_zero_n, head_side,
            index_pulse_n, write_protect_n, !head_inward_n};
    endproperty
    a_a1: assert property (p_a1) else $error("status A1");
    property p_a2;
        rd0 && compat_mode == 2'h2 |-> io_rdata_oe &&
            {io_rdata[7:6], io_rdata[4:0]} == {core_irq, core_drq,
            !track_zero_n, !head_side, !index_pulse_n, !write_protect_n,
            head_inward_n};
    endproperty
    a_a2: assert property (p_a2) else $error("status A two");
    property p_b1;
        io_rd && io_addr == 3'h1 && compat_mode == 2'h1 |->
            {io_rdata[7:5], io_rdata[2:0]} == {2'h3, digital_output[0],
            write_gate, digital_output[5:4]};
    endproperty
    a_b1: assert property (p_b1) else $error("status B1");
    c_a2: cover property (rd0 && compat_mode == 2'h2);
    c_dsr: cover property (io_wr && io_addr == 3'h4);
    c_fpd: cover property (floppy_power_off);
endmodule
bind fdsr_regs fdsr_regs_chk i_fdsr_regs_chk (.*);

//--- fdsr_toggle.sv
// Toggle flip-flop flipping on each falling edge of a sampled level.
// Assumes the input is synchronous to clk.
`timescale 1ns/1ps
module fdsr_toggle
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Watched level
    input wire logic level_in,
    // Toggle state
    output logic toggle_out
);

    logic level_reg;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            level_reg <= 1'b0;
        end
        else
        begin
            level_reg <= level_in;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            toggle_out <= 1'b0;
        end
        else if (level_reg && !level_in)
        begin
            toggle_out <= ~toggle_out;
        end
    end

endmodule

//--- floppy_status_regs_and_drive_power_pin_test.sv
// Self-checking bench for the floppy status register bank.
// Assumes fdsr_host drives the bus and the checker is bound.
`timescale 1ns/1ps
module floppy_status_regs_and_drive_power_pin_test;
    logic clk, reset_n, io_rd, io_wr, io_rdata_oe, fdc_shutdown, core_irq;
    logic auto_power_config, auto_powered_down, core_drq, soft_reset;
    logic fifo_rd, fifo_wr, head_inward_n, write_protect_n, index_pulse_n;
    logic track_zero_n, head_side, step_out, second_drive_present_n;
    logic write_gate, read_data_n, write_data_n, floppy_power_off, lat, rt, wt;
    logic [2:0] io_addr;
    logic [1:0] compat_mode, tape;
    logic [7:0] io_wdata, io_rdata, main_status, fifo_rdata, digital_input;
    logic [7:0] digital_output, data_rate_select, config_control, dout, d;
    int fails = 0, n_checks = 0, cyc = 0;
    fdsr_regs i_fdsr_regs (.*);
    fdsr_host i_fdsr_host (.*);
    always #5 clk = ~clk;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            fails++;
            finish_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] ex(input logic [2:0] a);
        case (a)
            3'h0: ex = compat_mode == 2'h1 ? {core_irq, second_drive_present_n,
                step_out, track_zero_n, head_side, index_pulse_n,
                write_protect_n, ~head_inward_n} : compat_mode == 2'h2 ?
                {core_irq, core_drq, lat, ~track_zero_n, ~head_side,
                ~index_pulse_n, ~write_protect_n, head_inward_n} : 8'h00;
            3'h1: ex = compat_mode == 2'h1 ? {2'h3, dout[0], wt, rt,
                write_gate, dout[5:4]} : 8'h00;
            3'h2: ex = dout;
            3'h3: ex = {6'h00, tape};
            3'h4: ex = main_status;
            3'h5: ex = fifo_rdata;
            3'h7: ex = digital_input;
            default: ex = 8'h00;
        endcase
    endfunction
    task automatic rchk(input logic [2:0] a);
        logic [7:0] v;
        logic oe;
        logic eoe;
        i_fdsr_host.rd(a, v, oe);
        eoe = !(a == 3'h6 || (a < 3'h2 && compat_mode == 2'h0));
        chk(v, ex(a));
        chk({7'h0, oe}, {7'h0, eoe});
    endtask
    task automatic rnd();
        @(posedge clk);
        {main_status, fifo_rdata, digital_input} <= 24'($urandom);
        {core_irq, core_drq, head_inward_n, write_protect_n, index_pulse_n,
            track_zero_n, head_side, second_drive_present_n,
            write_gate} <= 9'($urandom);
    endtask
    initial
    begin
        clk = 0;
        reset_n = 0;
        {compat_mode, fdc_shutdown, auto_power_config, auto_powered_down} = 0;
        {main_status, fifo_rdata, digital_input, core_irq, core_drq} = 0;
        {soft_reset, step_out, head_side, write_gate, lat, rt, wt} = 0;
        {head_inward_n, write_protect_n, index_pulse_n, track_zero_n} = 4'hF;
        {second_drive_present_n, read_data_n, write_data_n} = 3'h7;
        void'($urandom(32'h4045));
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chk(digital_output, 8'h00);
        dout = 8'($urandom) | 8'h04;
        tape = 2'($urandom);
        d = 8'($urandom);
        i_fdsr_host.wr(3'h2, dout);
        i_fdsr_host.wr(3'h3, {6'h2A, tape});
        i_fdsr_host.wr(3'h4, d);
        i_fdsr_host.wr(3'h7, ~d);
        i_fdsr_host.wr(3'h0, d);
        i_fdsr_host.wr(3'h1, d);
        i_fdsr_host.wr(3'h6, d);
        i_fdsr_host.wr(3'h5, d);
        @(negedge clk);
        chk(data_rate_select, d);
        chk(config_control, ~d);
        for (int m = 0; m < 3; m++)
        begin
            compat_mode <= m[1:0];
            for (int a = 0; a < 8; a++)
            begin
                rnd();
                rchk(a[2:0]);
            end
        end
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk) step_out <= 1'b1;
            @(posedge clk) step_out <= 1'b0;
            lat = 1'b1;
            rchk(3'h0);
            if (k == 0)
                rchk(3'h7);
            else
            begin
                @(posedge clk) soft_reset <= 1'b1;
                @(posedge clk) soft_reset <= 1'b0;
            end
            lat = 1'b0;
            rchk(3'h0);
        end
        compat_mode <= 2'h1;
        repeat (3)
        begin
            @(posedge clk) read_data_n <= 1'b0;
            @(posedge clk) read_data_n <= 1'b1;
            rt = ~rt;
        end
        repeat (3)
        begin
            @(posedge clk) write_data_n <= 1'b0;
            @(posedge clk) write_data_n <= 1'b1;
            wt = ~wt;
        end
        repeat (2) @(posedge clk);
        rchk(3'h1);
        for (int i = 0; i < 16; i++)
        begin
            i_fdsr_host.wr(3'h4, {1'b0, i[3], 6'h00});
            @(posedge clk)
            {fdc_shutdown, auto_power_config, auto_powered_down} <= i[2:0];
            repeat (3) @(negedge clk);
            chk({7'h0, floppy_power_off},
                {7'h0, i[2] | (i[1] ? i[0] : i[3])});
        end
        // Mid-run hard reset clears latch, toggles and digital output
        compat_mode <= 2'h2;
        @(posedge clk) step_out <= 1'b1;
        @(posedge clk) step_out <= 1'b0;
        @(posedge clk) reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        {dout, rt, wt, lat} = 0;
        @(negedge clk);
        chk(digital_output, 8'h00);
        rchk(3'h0);
        compat_mode <= 2'h1;
        rchk(3'h1);
        finish_test();
    end
endmodule
